// ---- dls_top.sv ----
// Dual-link skew, picture scroll and preset recall
// Overview of operation
// - Link B moves against link A by up to 15 steps each way.
// - Decrement and increment together set the skew back to zero.
// - Active picture shifts vertically, horizontally, or randomly.
// - Horizontal step is signed, within 252 samples, in multiples of four.
// - Vertical step is signed, within 252 lines, in single lines.
// - One scroll move every N frames, N from one to sixteen.
// - Random setting replaces the fixed steps with random moves.
// - Preset recall enters generator operation.
// - Preset recall zeroes skew and steps, period one, random off.
// - Preset recall selects 1080 GBR 4:4:4 12 bits, Y/G alpha, normal, link A.
`timescale 1ns/1ps
`include "dls_consts.svh"
module dls_top (
	input  wire logic                     i_ref_clk,
	input  wire logic                     i_rst,
	input  wire logic [`DLS_ADDR_W-1:0]   i_addr,
	input  wire logic [31:0]              i_wdata,
	input  wire logic                     i_wr,
	input  wire logic                     i_rd,
	output logic [31:0]                   o_rdata,
	input  wire logic                     i_frame_start,
	input  wire dls_pkg::dls_vid_t        i_vid_data,
	output dls_pkg::dls_vid_t             o_link_a_data,
	output dls_pkg::dls_vid_t             o_link_b_data,
	output dls_pkg::dls_pos_t             o_h_offset,
	output dls_pkg::dls_pos_t             o_v_offset,
	output dls_pkg::dls_skew_t            o_skew,
	output logic                          o_gen_mode,
	output logic                          o_conv_map,
	output dls_pkg::dls_aud_t             o_aud_link,
	output logic [3:0]                    o_alpha_sel,
	output logic [3:0]                    o_fmt_sel
);
	import dls_pkg::*;

	// Cycles per skew step, steps to each limit, and centre delay
	localparam int SKEW_CYC   = (`DLS_SKEW_STEP_PS + `DLS_CLK_PS - 1) / `DLS_CLK_PS;
	localparam int SKEW_STEPS = (`DLS_SKEW_LIM_PS + `DLS_SKEW_STEP_PS / 2) / `DLS_SKEW_STEP_PS;
	localparam int SKEW_BASE  = SKEW_STEPS * SKEW_CYC;

	dls_skew_t   skew_ff;
	dls_skew_t   nxt_skew;
	dls_step_t   hstep_ff;
	dls_step_t   nxt_hstep;
	dls_step_t   vstep_ff;
	dls_step_t   nxt_vstep;
	dls_period_t period_ff;
	dls_period_t nxt_period;
	logic        random_ff;
	logic        nxt_random;
	logic        gen_ff;
	logic        nxt_gen;
	logic        map_ff;
	logic        nxt_map;
	dls_aud_t    aud_ff;
	dls_aud_t    nxt_aud;
	logic [3:0]  alpha_ff;
	logic [3:0]  nxt_alpha;
	logic [3:0]  fmt_ff;
	logic [3:0]  nxt_fmt;
	dls_period_t pcnt_ff;
	dls_period_t nxt_pcnt;
	dls_pos_t    hpos_ff;
	dls_pos_t    nxt_hpos;
	dls_pos_t    vpos_ff;
	dls_pos_t    nxt_vpos;
	logic [15:0] lfsr_ff;
	logic [15:0] nxt_lfsr;
	dls_maddr_t  wptr_ff;
	dls_maddr_t  nxt_wptr;
	logic        fill_ff;
	logic        nxt_fill;
	dls_vid_t    link_a_ff;
	dls_vid_t    nxt_link_a;
	dls_vid_t    link_b_ff;
	dls_vid_t    nxt_link_b;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic        ctrl_wr;
	logic        preset;

	dls_mem_if mem_if ();

	dls_delay_mem u_mem (
		.i_ref_clk (i_ref_clk),
		.mem       (mem_if.mem)
	);

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	// Clamp a signed write value to plus or minus the limit
	function automatic dls_step_t sat_step(input logic signed [31:0] v,
		input logic signed [31:0] lim);
		logic signed [31:0] r;
		r = v;
		if (v > lim) begin
			r = lim;
		end else if (v < -lim) begin
			r = -lim;
		end
		return r[9:0];
	endfunction

	// ==========================================
	// Settings
	assign ctrl_wr = i_wr && (i_addr == `DLS_REG_CTRL);
	assign preset  = ctrl_wr && i_wdata[`DLS_CTRL_PRESET];

	// Next values of the settings from bus writes
	always_comb begin
		nxt_skew   = skew_ff;
		nxt_hstep  = hstep_ff;
		nxt_vstep  = vstep_ff;
		nxt_period = period_ff;
		nxt_random = random_ff;
		nxt_gen    = gen_ff;
		nxt_map    = map_ff;
		nxt_aud    = aud_ff;
		nxt_alpha  = alpha_ff;
		nxt_fmt    = fmt_ff;
		if (preset) begin
			nxt_gen    = 1'b1;
			nxt_skew   = '0;
			nxt_hstep  = '0;
			nxt_vstep  = '0;
			nxt_period = 5'(`DLS_PERIOD_MIN);
			nxt_random = 1'b0;
			nxt_fmt    = `DLS_FMT_GBR444_12;
			nxt_alpha  = `DLS_ALPHA_YG;
			nxt_map    = `DLS_MAP_NORMAL;
			nxt_aud    = DLS_AUD_A;
		end else if (ctrl_wr) begin
			if (i_wdata[`DLS_CTRL_DEC] && i_wdata[`DLS_CTRL_INC]) begin
				nxt_skew = '0;
			end else if (i_wdata[`DLS_CTRL_INC] && (int'(skew_ff) < SKEW_STEPS)) begin
				nxt_skew = 5'(skew_ff + 5'sh01);
			end else if (i_wdata[`DLS_CTRL_DEC] && (int'(skew_ff) > -SKEW_STEPS)) begin
				nxt_skew = 5'(skew_ff - 5'sh01);
			end
		end else if (i_wr) begin
			unique case (i_addr)
				`DLS_REG_HSTEP: begin
					// clamp and keep multiples of four
					nxt_hstep = sat_step(i_wdata, `DLS_HSTEP_LIM);
					nxt_hstep[`DLS_HSTEP_LSBS-1:0] = '0;
				end
				`DLS_REG_VSTEP: begin
					nxt_vstep = sat_step(i_wdata, `DLS_VSTEP_LIM);
				end
				`DLS_REG_PERIOD: begin
					if (i_wdata < 32'(`DLS_PERIOD_MIN)) begin
						nxt_period = 5'(`DLS_PERIOD_MIN);
					end else if (i_wdata > 32'(`DLS_PERIOD_MAX)) begin
						nxt_period = 5'(`DLS_PERIOD_MAX);
					end else begin
						nxt_period = i_wdata[4:0];
					end
				end
				`DLS_REG_RANDOM: begin
					nxt_random = i_wdata[0];
				end
				`DLS_REG_MODE: begin
					nxt_gen   = i_wdata[`DLS_MODE_GEN];
					nxt_map   = i_wdata[`DLS_MODE_MAP];
					nxt_aud   = (i_wdata[`DLS_MODE_AUD] == 2'h3) ? aud_ff
						: dls_aud_t'(i_wdata[`DLS_MODE_AUD]);
					nxt_alpha = i_wdata[`DLS_MODE_ALPHA];
					nxt_fmt   = i_wdata[`DLS_MODE_FMT];
				end
				default: begin
				end
			endcase
		end
	end

	// Register the settings; reset loads the factory defaults
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			skew_ff   <= '0;
			hstep_ff  <= '0;
			vstep_ff  <= '0;
			period_ff <= 5'(`DLS_PERIOD_MIN);
			random_ff <= 1'b0;
			gen_ff    <= 1'b1;
			map_ff    <= `DLS_MAP_NORMAL;
			aud_ff    <= DLS_AUD_A;
			alpha_ff  <= `DLS_ALPHA_YG;
			fmt_ff    <= `DLS_FMT_GBR444_12;
		end else begin
			skew_ff   <= nxt_skew;
			hstep_ff  <= nxt_hstep;
			vstep_ff  <= nxt_vstep;
			period_ff <= nxt_period;
			random_ff <= nxt_random;
			gen_ff    <= nxt_gen;
			map_ff    <= nxt_map;
			aud_ff    <= nxt_aud;
			alpha_ff  <= nxt_alpha;
			fmt_ff    <= nxt_fmt;
		end
	end

	sequence s_preset;
		i_wr && (i_addr == `DLS_REG_CTRL) && i_wdata[`DLS_CTRL_PRESET];
	endsequence
	sequence s_both_keys;
		i_wr && (i_addr == `DLS_REG_CTRL) && (i_wdata[1:0] == 2'h3);
	endsequence

	skew_limit_a: assert property (int'(skew_ff) <= 15 && int'(skew_ff) >= -15)
		else $error("skew outside range");
	skew_zero_a: assert property (s_both_keys |=> skew_ff == 5'sh00)
		else $error("skew not zeroed");
	hstep_grain_a: assert property (hstep_ff[1:0] == 2'h0 && hstep_ff <= 10'sd252
		&& hstep_ff >= -10'sd252) else $error("horizontal step illegal");
	vstep_range_a: assert property (vstep_ff <= 10'sd252 && vstep_ff >= -10'sd252)
		else $error("vertical step illegal");
	preset_scroll_a: assert property (s_preset |=> skew_ff == 5'sh00 && hstep_ff == '0
		&& vstep_ff == '0 && period_ff == 5'h01 && !random_ff) else $error("preset scroll");
	preset_mode_a: assert property (s_preset |=> gen_ff && fmt_ff == 4'h0
		&& alpha_ff == 4'h0 && !map_ff && aud_ff == DLS_AUD_A) else $error("preset mode");
	preset_gen_a: assert property (s_preset ##1 !i_wr [*2] |-> gen_ff)
		else $error("preset left converter mode");

	// ==========================================
	// Scroll position
	always_comb begin
		int        h;
		int        v;
		dls_step_t hs;
		dls_step_t vs;
		h = 0;
		v = 0;
		nxt_lfsr = {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
		nxt_pcnt = pcnt_ff;
		nxt_hpos = hpos_ff;
		nxt_vpos = vpos_ff;
		// random moves replace the fixed steps
		hs = random_ff ? 10'(signed'({lfsr_ff[7:2], 2'h0})) : hstep_ff;
		vs = random_ff ? 10'(signed'(lfsr_ff[15:8])) : vstep_ff;
		if (preset) begin
			nxt_pcnt = '0;
			nxt_hpos = '0;
			nxt_vpos = '0;
		// move only on a frame boundary
		end else if (i_frame_start) begin
			// one move per period of frames
			if (int'(pcnt_ff) + 1 >= int'(period_ff)) begin
				nxt_pcnt = '0;
				h = int'(hpos_ff) + int'(hs);
				v = int'(vpos_ff) + int'(vs);
				if (h < 0) begin
					h = h + `DLS_ACT_W;
				end else if (h >= `DLS_ACT_W) begin
					h = h - `DLS_ACT_W;
				end
				if (v < 0) begin
					v = v + `DLS_ACT_H;
				end else if (v >= `DLS_ACT_H) begin
					v = v - `DLS_ACT_H;
				end
				nxt_hpos = 11'(h);
				nxt_vpos = 11'(v);
			end else begin
				nxt_pcnt = 5'(pcnt_ff + 5'h01);
			end
		end
	end

	// Register the scroll state
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			lfsr_ff <= `DLS_LFSR_SEED;
			pcnt_ff <= '0;
			hpos_ff <= '0;
			vpos_ff <= '0;
		end else begin
			lfsr_ff <= nxt_lfsr;
			pcnt_ff <= nxt_pcnt;
			hpos_ff <= nxt_hpos;
			vpos_ff <= nxt_vpos;
		end
	end

	pos_wrap_a: assert property (hpos_ff < 11'd1920 && vpos_ff < 11'd1080)
		else $error("displacement not wrapped");
	frame_only_a: assert property ((hpos_ff != $past(hpos_ff) || vpos_ff != $past(vpos_ff))
		|-> $past(i_frame_start) || $past(preset)) else $error("move outside frame boundary");
	period_count_a: assert property (i_frame_start && !preset && pcnt_ff == 5'h00
		&& period_ff > 5'h01 |=> pcnt_ff == 5'h01) else $error("frame interval count");
	fixed_step_a: assert property (i_frame_start && !preset && !random_ff
		&& period_ff == 5'h01 && hstep_ff == '0 && vstep_ff == '0 |=> $stable(hpos_ff)
		&& $stable(vpos_ff)) else $error("zero step moved picture");

	// ==========================================
	// Link delay line
	always_comb begin
		logic [7:0] dly_b;
		dly_b = 8'(SKEW_BASE + int'(skew_ff) * SKEW_CYC);
		nxt_wptr       = 7'(wptr_ff + 7'h01);
		nxt_fill       = fill_ff || (wptr_ff == 7'h7F);
		mem_if.we      = 1'b1;
		mem_if.waddr   = wptr_ff;
		mem_if.wdata   = i_vid_data;
		mem_if.raddr_a = 7'(wptr_ff - 7'(SKEW_BASE));
		// link B delay follows the skew setting
		mem_if.raddr_b = 7'(wptr_ff - dly_b[6:0]);
		nxt_link_a     = fill_ff ? mem_if.rdata_a : '0;
		nxt_link_b     = fill_ff ? mem_if.rdata_b : '0;
	end

	// Register pointer and link outputs
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			wptr_ff   <= '0;
			fill_ff   <= 1'b0;
			link_a_ff <= '0;
			link_b_ff <= '0;
		end else begin
			wptr_ff   <= nxt_wptr;
			fill_ff   <= nxt_fill;
			link_a_ff <= nxt_link_a;
			link_b_ff <= nxt_link_b;
		end
	end

	// ==========================================
	// Register read port
	always_comb begin
		nxt_rdata = '0;
		if (i_rd) begin
			unique case (i_addr)
				`DLS_REG_SKEW:   nxt_rdata = 32'(skew_ff);
				`DLS_REG_HSTEP:  nxt_rdata = 32'(hstep_ff);
				`DLS_REG_VSTEP:  nxt_rdata = 32'(vstep_ff);
				`DLS_REG_PERIOD: nxt_rdata = 32'(period_ff);
				`DLS_REG_RANDOM: nxt_rdata = 32'(random_ff);
				`DLS_REG_MODE:   nxt_rdata = {20'h00000, fmt_ff, alpha_ff, aud_ff, map_ff, gen_ff};
				`DLS_REG_HPOS:   nxt_rdata = 32'(hpos_ff);
				`DLS_REG_VPOS:   nxt_rdata = 32'(vpos_ff);
				default:         nxt_rdata = '0;
			endcase
		end
	end

	// Read data stand one cycle
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	skew_read_a: assert property (i_rd && i_addr == `DLS_REG_SKEW |=>
		o_rdata == 32'($past(skew_ff))) else $error("skew readback");

	// Outputs
	assign o_rdata       = rdata_ff;
	assign o_link_a_data = link_a_ff;
	assign o_link_b_data = link_b_ff;
	assign o_h_offset    = hpos_ff;
	assign o_v_offset    = vpos_ff;
	assign o_skew        = skew_ff;
	assign o_gen_mode    = gen_ff;
	assign o_conv_map    = map_ff;
	assign o_aud_link    = aud_ff;
	assign o_alpha_sel   = alpha_ff;
	assign o_fmt_sel     = fmt_ff;
endmodule

// ---- dls_consts.svh ----
// Constants for the dual-link skew and scroll block
`ifndef DLS_CONSTS_SVH
`define DLS_CONSTS_SVH
// ==========================================
// Register offsets (byte addresses)
`define DLS_ADDR_W        8
`define DLS_REG_CTRL      8'h00
`define DLS_REG_SKEW      8'h04
`define DLS_REG_HSTEP     8'h08
`define DLS_REG_VSTEP     8'h0C
`define DLS_REG_PERIOD    8'h10
`define DLS_REG_RANDOM    8'h14
`define DLS_REG_MODE      8'h18
`define DLS_REG_HPOS      8'h1C
`define DLS_REG_VPOS      8'h20
// ==========================================
// Field positions
`define DLS_CTRL_DEC      0
`define DLS_CTRL_INC      1
`define DLS_CTRL_PRESET   2
`define DLS_MODE_GEN      0
`define DLS_MODE_MAP      1
`define DLS_MODE_AUD      3:2
`define DLS_MODE_ALPHA    7:4
`define DLS_MODE_FMT      11:8
// ==========================================
// Timing and ranges
`define DLS_CLK_PS        5000
`define DLS_SKEW_STEP_PS  13500
`define DLS_SKEW_LIM_PS   202000
`define DLS_HSTEP_LIM     252
`define DLS_VSTEP_LIM     252
`define DLS_HSTEP_LSBS    2
`define DLS_PERIOD_MIN    1
`define DLS_PERIOD_MAX    16
`define DLS_ACT_W         1920
`define DLS_ACT_H         1080
`define DLS_MEM_DEPTH     128
`define DLS_MEM_AW        7
`define DLS_VID_W         20
// ==========================================
// Factory-default values
`define DLS_FMT_GBR444_12 4'h0
`define DLS_ALPHA_YG      4'h0
`define DLS_MAP_NORMAL    1'b0
`define DLS_LFSR_SEED     16'hACE1
`endif

// ---- dls_pkg.sv ----
// Types shared by the skew and scroll block
`include "dls_consts.svh"
package dls_pkg;
	typedef logic signed [4:0]            dls_skew_t;
	typedef logic signed [9:0]            dls_step_t;
	typedef logic [4:0]                   dls_period_t;
	typedef logic [10:0]                  dls_pos_t;
	typedef logic [`DLS_VID_W-1:0]        dls_vid_t;
	typedef logic [`DLS_MEM_AW-1:0]       dls_maddr_t;
	typedef enum logic [1:0] {
		DLS_AUD_A  = 2'h0,
		DLS_AUD_B  = 2'h1,
		DLS_AUD_AB = 2'h2
	} dls_aud_t;
endpackage

// ---- dls_mem_if.sv ----
// Connection between the block and its delay-line memory
`timescale 1ns/1ps
`include "dls_consts.svh"
interface dls_mem_if;
	import dls_pkg::*;
	logic       we;
	dls_maddr_t waddr;
	dls_maddr_t raddr_a;
	dls_maddr_t raddr_b;
	dls_vid_t   wdata;
	dls_vid_t   rdata_a;
	dls_vid_t   rdata_b;
	modport mem  (input we, waddr, wdata, raddr_a, raddr_b, output rdata_a, rdata_b);
	modport user (output we, waddr, wdata, raddr_a, raddr_b, input rdata_a, rdata_b);
endinterface

// ---- dls_delay_mem.sv ----
// Sample delay line: one write port, two registered read ports
`timescale 1ns/1ps
`include "dls_consts.svh"
module dls_delay_mem (
	input wire logic i_ref_clk,
	dls_mem_if.mem   mem
);
	import dls_pkg::*;

	dls_vid_t store [`DLS_MEM_DEPTH];
	dls_vid_t nxt_rdata_a;
	dls_vid_t nxt_rdata_b;

	// ==========================================
	// Read ports
	always_comb begin
		nxt_rdata_a = store[mem.raddr_a];
		nxt_rdata_b = store[mem.raddr_b];
		// Forward the sample being written, so the shortest link B delay still works
		if (mem.we && (mem.waddr == mem.raddr_a)) begin
			nxt_rdata_a = mem.wdata;
		end
		if (mem.we && (mem.waddr == mem.raddr_b)) begin
			nxt_rdata_b = mem.wdata;
		end
	end

	// Write and register the read data
	always_ff @(posedge i_ref_clk) begin
		if (mem.we) begin
			store[mem.waddr] <= mem.wdata;
		end
		mem.rdata_a <= nxt_rdata_a;
		mem.rdata_b <= nxt_rdata_b;
	end
endmodule

// ---- dls_link_rx.sv ----
// Receiver model for the two link outputs of the skew block
`timescale 1ns/1ps
module dls_link_rx (
	input  wire logic              i_ref_clk,
	input  wire dls_pkg::dls_vid_t i_link_a,
	input  wire dls_pkg::dls_vid_t i_link_b,
	output dls_pkg::dls_vid_t      o_lag
);
	import dls_pkg::*;
	// ==========================================
	// Lag of link B behind link A, valid for a ramp source
	always_ff @(posedge i_ref_clk) begin
		o_lag <= i_link_a - i_link_b;
	end
endmodule

// ---- dls_top_tb.sv ----
// Self-checking bench for the skew and scroll block
`timescale 1ns/1ps
`include "dls_consts.svh"
module dls_top_tb;
	import dls_pkg::*;
	logic              i_ref_clk;
	logic              i_rst;
	logic [7:0]        i_addr;
	logic [31:0]       i_wdata;
	logic              i_wr;
	logic              i_rd;
	logic              i_frame_start;
	dls_vid_t          i_vid_data;
	logic [31:0]       o_rdata;
	dls_vid_t          o_link_a_data;
	dls_vid_t          o_link_b_data;
	dls_pos_t          o_h_offset;
	dls_pos_t          o_v_offset;
	dls_skew_t         o_skew;
	logic              o_gen_mode;
	logic              o_conv_map;
	dls_aud_t          o_aud_link;
	logic [3:0]        o_alpha_sel;
	logic [3:0]        o_fmt_sel;
	dls_vid_t          lag;
	int                num_errors;
	int                checks;
	logic [31:0]       rd_val;
	// Table rows: address, write data, expected read-back
	logic [71:0]       rows [13] = '{
		{8'h08, 32'h0000_0010, 32'h0000_0010},
		{8'h08, 32'hFFFF_FFF9, 32'hFFFF_FFF8},
		{8'h08, 32'h0000_012C, 32'h0000_00FC},
		{8'h08, 32'hFFFF_FED4, 32'hFFFF_FF04},
		{8'h0C, 32'hFFFF_FFFB, 32'hFFFF_FFFB},
		{8'h0C, 32'h0000_00FD, 32'h0000_00FC},
		{8'h10, 32'h0000_0000, 32'h0000_0001},
		{8'h10, 32'h0000_0014, 32'h0000_0010},
		{8'h10, 32'h0000_0010, 32'h0000_0010},
		{8'h14, 32'h0000_0001, 32'h0000_0001},
		{8'h14, 32'h0000_0000, 32'h0000_0000},
		{8'h18, 32'h0000_0009, 32'h0000_0009},
		{8'h40, 32'h0000_00FF, 32'h0000_0000}
	};
	// ==========================================
	// Design and receiver
	dls_top u_dls_top (
		.i_ref_clk     (i_ref_clk),
		.i_rst         (i_rst),
		.i_addr        (i_addr),
		.i_wdata       (i_wdata),
		.i_wr          (i_wr),
		.i_rd          (i_rd),
		.o_rdata       (o_rdata),
		.i_frame_start (i_frame_start),
		.i_vid_data    (i_vid_data),
		.o_link_a_data (o_link_a_data),
		.o_link_b_data (o_link_b_data),
		.o_h_offset    (o_h_offset),
		.o_v_offset    (o_v_offset),
		.o_skew        (o_skew),
		.o_gen_mode    (o_gen_mode),
		.o_conv_map    (o_conv_map),
		.o_aud_link    (o_aud_link),
		.o_alpha_sel   (o_alpha_sel),
		.o_fmt_sel     (o_fmt_sel)
	);
	dls_link_rx u_dls_link_rx (
		.i_ref_clk (i_ref_clk),
		.i_link_a  (o_link_a_data),
		.i_link_b  (o_link_b_data),
		.o_lag     (lag)
	);
	// ==========================================
	// Clock and ramp video source
	initial begin
		i_ref_clk = 1'b0;
		forever #2.5 i_ref_clk = ~i_ref_clk;
	end
	always @(posedge i_ref_clk) begin
		i_vid_data <= i_vid_data + 20'h00001;
	end
	// ==========================================
	// Helpers
	task automatic end_of_test();
		if (num_errors == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge i_ref_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1 rd_val = o_rdata;
	endtask
	task automatic frame();
		@(posedge i_ref_clk);
		i_frame_start <= 1'b1;
		@(posedge i_ref_clk);
		i_frame_start <= 1'b0;
		#1;
	endtask
	task automatic pos_chk(input logic [10:0] h, input logic [10:0] v);
		chk("h_offset", 32'(o_h_offset), 32'(h));
		chk("v_offset", 32'(o_v_offset), 32'(v));
	endtask
	task automatic dflt_chk();
		chk("skew", 32'(o_skew), 32'h0);
		chk("gen", 32'(o_gen_mode), 32'h1);
		chk("fmt_alpha", {24'h0, o_fmt_sel, o_alpha_sel}, 32'h0);
		chk("map_aud", {29'h0, o_conv_map, o_aud_link}, 32'h0);
		pos_chk(11'h000, 11'h000);
		rd(`DLS_REG_HSTEP);
		chk("hstep", rd_val, 32'h0);
		rd(`DLS_REG_VSTEP);
		chk("vstep", rd_val, 32'h0);
		rd(`DLS_REG_PERIOD);
		chk("period", rd_val, 32'h1);
		rd(`DLS_REG_RANDOM);
		chk("random", rd_val, 32'h0);
		rd(`DLS_REG_MODE);
		chk("mode", rd_val, 32'h1);
	endtask
	// Watchdog against a hang
	initial begin
		repeat (20000) @(posedge i_ref_clk);
		num_errors++;
		end_of_test();
	end
	// ==========================================
	// Main sequence
	initial begin
		num_errors = 0;
		checks = 0;
		i_rst = 1'b1;
		i_addr = 8'h00;
		i_wdata = 32'h0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_frame_start = 1'b0;
		i_vid_data = 20'h00000;
		repeat (6) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		dflt_chk();
		// Table of register writes and read-backs
		foreach (rows[i]) begin
			wr(rows[i][71:64], rows[i][63:32]);
			rd(rows[i][71:64]);
			chk("table", rd_val, rows[i][31:0]);
		end
		// Skew saturates at +15 steps, link B lags by three cycles a step
		repeat (16) wr(`DLS_REG_CTRL, 32'h2);
		chk("skew_max", 32'(o_skew), 32'h0000_000F);
		repeat (200) @(posedge i_ref_clk);
		chk("lag_max", 32'(lag), 32'h0000_002D);
		repeat (31) wr(`DLS_REG_CTRL, 32'h1);
		rd(`DLS_REG_SKEW);
		chk("skew_min", rd_val, 32'hFFFF_FFF1);
		repeat (200) @(posedge i_ref_clk);
		chk("lag_min", 32'(lag), 32'h000F_FFD3);
		wr(`DLS_REG_CTRL, 32'h3);
		chk("skew_zero", 32'(o_skew), 32'h0);
		repeat (200) @(posedge i_ref_clk);
		chk("lag_zero", 32'(lag), 32'h0);
		#1;
		chk("link_a_delay", 32'(dls_vid_t'(i_vid_data - o_link_a_data)), 32'd47);
		// Fixed scroll with wrap in both axes
		wr(`DLS_REG_HSTEP, 32'h4);
		wr(`DLS_REG_VSTEP, 32'hFFFF_FF04);
		wr(`DLS_REG_PERIOD, 32'h1);
		frame();
		pos_chk(11'd4, 11'd828);
		frame();
		pos_chk(11'd8, 11'd576);
		wr(`DLS_REG_HSTEP, 32'hFFFF_FFF4);
		frame();
		pos_chk(11'd1916, 11'd324);
		rd(`DLS_REG_HPOS);
		chk("hpos", rd_val, 32'd1916);
		rd(`DLS_REG_VPOS);
		chk("vpos", rd_val, 32'd324);
		// Period of three frames: only the third pulse moves
		wr(`DLS_REG_PERIOD, 32'h3);
		frame();
		pos_chk(11'd1916, 11'd324);
		repeat (20) @(posedge i_ref_clk);
		frame();
		pos_chk(11'd1916, 11'd324);
		frame();
		pos_chk(11'd1904, 11'd72);
		// Random scroll keeps the four-sample grid
		wr(`DLS_REG_RANDOM, 32'h1);
		wr(`DLS_REG_PERIOD, 32'h1);
		frame();
		chk("rand_grid", 32'(o_h_offset[1:0]), 32'h0);
		// Mode fields, refused audio code, then preset over dec and inc
		wr(`DLS_REG_MODE, 32'h0000_05A6);
		chk("gen_off", 32'(o_gen_mode), 32'h0);
		chk("fmt_alpha_set", {24'h0, o_fmt_sel, o_alpha_sel}, 32'h5A);
		chk("map_aud_set", {29'h0, o_conv_map, o_aud_link}, 32'h5);
		wr(`DLS_REG_MODE, 32'h0000_05AE);
		rd(`DLS_REG_MODE);
		chk("mode_keep", rd_val, 32'h0000_05A6);
		repeat (3) wr(`DLS_REG_CTRL, 32'h2);
		wr(`DLS_REG_CTRL, 32'h7);
		dflt_chk();
		// Zero steps keep the picture still, then a mid-run reset restores defaults
		frame();
		pos_chk(11'h000, 11'h000);
		wr(`DLS_REG_CTRL, 32'h2);
		wr(`DLS_REG_HSTEP, 32'h8);
		@(posedge i_ref_clk);
		i_rst <= 1'b1;
		repeat (3) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		chk("link_rst", 32'(o_link_a_data), 32'h0);
		dflt_chk();
		end_of_test();
	end
endmodule
